// *** egress_map_and_vlan_pop.sv ***
// egress_map_and_vlan_pop: mapping lookups, tcam action use, tag pop
// assumes per-frame port config is selected by the caller
// Operation
// - two mapping resources each hold all mapped fields per entry
// - two lookups per resource per frame give tables zero to three
// - address is tcam base index on top, selected frame key below
// - base index counts in eight-entry units
// - key value two uses frame dscp, sixty-four entries
// - a key not derivable from the frame makes the lookup invalid
// - table one else zero else no valid result; three else two likewise
// - outer priority select five takes priority from table one chain
// - tables zero/one share resource a, two/three share resource b
// - edit order: tcam, pop, push decision, construction, push
// - tcam lookup only when globally enabled; it steers pushing
// - push decision gives tag count and source per tag
// - pop the header count, up to three tags
// - tcam extra pop raises the count by one
// - never pop more tags than the frame carries
// - require-original-tag blocks port tag unless frame originally_tagged_flag or tcam push_outer two forces it
// - four port tagging modes and per-port tpid/vid/pcp/dei select
// - global map from drop level to drop-eligible color
// - per-port remaps by class and color give pcp and dei
// - port default vid feeds port tag and the untagged compare
// - outermost tag may follow port config instead of tcam
`timescale 1ns/10ps
`default_nettype none
module egress_map_and_vlan_pop
    import egress_map_pkg::*;
(
    // clock and reset
    input  wire logic                             core_clk_i,
    input  wire logic                             reset_i,
    // global config
    input  wire logic                             tcam_enable_i,
    input  wire logic [3:0]                       drop_level_to_color_i,
    input  wire logic [NUM_CUSTOM_TPID-1:0][15:0] custom_tag_protocol_id_i,
    // table write
    input  wire logic                             map_wr_en_i,
    input  wire logic                             map_wr_res_i,
    input  wire logic [ADDR_W-1:0]                map_wr_addr_i,
    input  wire egress_map_pkg::map_entry_t       map_wr_data_i,
    // frame in
    input  wire logic                             in_valid_i,
    output logic                                  in_ready_o,
    input  wire egress_map_pkg::frame_info_t      frame_i,
    input  wire egress_map_pkg::tcam_action_t     action_i,
    input  wire egress_map_pkg::port_cfg_t        port_cfg_i,
    // result out
    output logic                                  out_valid_o,
    input  wire logic                             out_ready_i,
    output egress_map_pkg::edit_result_t          result_o
);
    import egress_map_pkg::*;

    logic                       stall;
    tcam_action_t               act;
    logic [3:0]                 key_ok;
    logic [3:0][ADDR_W-1:0]     rd_addr;
    map_entry_t [1:0]           res_a;
    map_entry_t [1:0]           res_b;
    logic [2:0]                 present;
    logic [2:0]                 pop;
    logic                       s1_valid;
    logic                       s1_tcam_en;
    frame_info_t                s1_frame;
    tcam_action_t               s1_act;
    port_cfg_t                  s1_port;
    logic [3:0]                 s1_key_ok;
    logic [2:0]                 s1_present;
    logic [2:0]                 s1_pop;
    edit_result_t               next_result;
    logic                       color;
    logic                       forced_port;
    logic                       port_tag;

    // key decode, shared by four lookups
    function automatic logic [8:0] key_lsb(input logic [3:0] k, input frame_info_t f,
                                           input logic [3:0] drop_level_to_color);
        logic de;
        de = drop_level_to_color[f.dp];
        case (key_sel_t'(k))
            KEY_PCP:       key_lsb = {1'b1, 5'h0, f.pcp};
            KEY_DEI_PCP:   key_lsb = {1'b1, 4'h0, f.dei, f.pcp};
            KEY_DSCP:      key_lsb = {f.is_ip, 2'h0, f.dscp};
            KEY_TC:        key_lsb = {f.is_mpls, 5'h0, f.tc};
            KEY_QOS:       key_lsb = {1'b1, 5'h0, f.qos_class};
            KEY_DP_QOS:    key_lsb = {1'b1, 3'h0, f.dp, f.qos_class};
            KEY_COLOR_QOS: key_lsb = {1'b1, 4'h0, de, f.qos_class};
            KEY_COSID:     key_lsb = {1'b1, 5'h0, f.cosid};
            KEY_VID:       key_lsb = {1'b1, f.vid[7:0]};
            default:       key_lsb = 9'h000;
        endcase
    endfunction

    // fallback chain between a pair of tables
    function automatic logic [$bits(map_entry_t):0] pick(input logic ok_hi, input logic ok_lo,
                                                         input map_entry_t hi, input map_entry_t lo);
        if (ok_hi) begin
            pick = {1'b1, hi};
        end else if (ok_lo) begin
            pick = {1'b1, lo};
        end else begin
            pick = '0;
        end
    endfunction

    assign stall      = out_valid_o && !out_ready_i;
    assign in_ready_o = !stall;

    // tcam hit, push and extra pop count only when enabled
    always_comb begin
        act     = action_i;
        act.hit = action_i.hit && tcam_enable_i;
        if (!act.hit) begin
            act.push_outer     = 2'h0;
            act.push_inner     = 1'b0;
            act.tcam_extra_pop = 1'b0;
        end
    end

    // lookup addresses: base in eight-entry units plus key
    for (genvar t = 0; t < NUM_TABLES; t++) begin : g_addr
        logic [8:0] k;
        assign k          = key_lsb(act.key_select[t], frame_i, drop_level_to_color_i);
        assign key_ok[t]  = k[8] && act.hit;
        assign rd_addr[t] = ADDR_W'({act.table_base_index[t], 3'h0} + {3'h0, k[7:0]});
    end

    // tables zero and one in resource a
    mapping_resource #(
        .DEPTH (MAP_DEPTH)
    ) u_res_a (
        .core_clk_i (core_clk_i),
        .wr_en_i    (map_wr_en_i && !map_wr_res_i),
        .wr_addr_i  (map_wr_addr_i),
        .wr_data_i  (map_wr_data_i),
        .rd_en_i    (!stall),
        .rd_addr_i  ({rd_addr[1], rd_addr[0]}),
        .rd_data_o  (res_a)
    );

    // tables two and three in resource b
    mapping_resource #(
        .DEPTH (MAP_DEPTH)
    ) u_res_b (
        .core_clk_i (core_clk_i),
        .wr_en_i    (map_wr_en_i && map_wr_res_i),
        .wr_addr_i  (map_wr_addr_i),
        .wr_data_i  (map_wr_data_i),
        .rd_en_i    (!stall),
        .rd_addr_i  ({rd_addr[3], rd_addr[2]}),
        .rd_data_o  (res_b)
    );

    // tag count and pop bound
    vlan_tag_scan u_scan (
        .ethertypes_i             (frame_i.ethertypes),
        .custom_tag_protocol_id_i (custom_tag_protocol_id_i),
        .header_pop_i             (frame_i.header_tag_pop_count),
        .extra_pop_i              (act.tcam_extra_pop),
        .present_o                (present),
        .pop_o                    (pop)
    );

    // stage one valid
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            s1_valid <= 1'b0;
        end else if (!stall) begin
            s1_valid <= in_valid_i;
        end
    end

    // stage one descriptor, tcam then pop
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            s1_tcam_en <= 1'b0;
            s1_frame   <= '0;
            s1_act     <= '0;
            s1_port    <= '0;
            s1_key_ok  <= 4'h0;
            s1_present <= 3'h0;
            s1_pop     <= 3'h0;
        end else if (!stall) begin
            s1_tcam_en <= tcam_enable_i;
            s1_frame   <= frame_i;
            s1_act     <= act;
            s1_port    <= port_cfg_i;
            s1_key_ok  <= key_ok;
            s1_present <= present;
            s1_pop     <= pop;
        end
    end

    assign color       = drop_level_to_color_i[s1_frame.dp];
    assign forced_port = s1_act.push_outer == 2'h2;

    // port tag allowed by mode and original tag flag
    always_comb begin
        case (tag_mode_t'(s1_port.tag_mode))
            MODE_ALL:      port_tag = 1'b1;
            MODE_EXC_PVID: port_tag = s1_frame.vid != 12'h000
                                   && s1_frame.vid != s1_port.port_default_vid;
            MODE_EXC_ZERO: port_tag = s1_frame.vid != 12'h000;
            default:       port_tag = 1'b0;
        endcase
        if (s1_port.require_original_tag && !s1_frame.originally_tagged_flag) begin
            port_tag = 1'b0;
        end
    end

    // result: map chains, push decision, port tag fields
    always_comb begin
        next_result = '0;
        {next_result.map_lo_valid, next_result.map_lo} =
            pick(s1_key_ok[1], s1_key_ok[0], res_a[1], res_a[0]);
        {next_result.map_hi_valid, next_result.map_hi} =
            pick(s1_key_ok[3], s1_key_ok[2], res_b[1], res_b[0]);
        next_result.pop_count    = s1_pop;
        next_result.present_tags = s1_present;
        if (s1_act.outer_tag_priority_select == PCP_SEL_MAPPED && next_result.map_lo_valid) begin
            next_result.outer_pcp = next_result.map_lo.mapped_priority_code;
        end else if (s1_act.outer_tag_priority_select == PCP_SEL_MAPPED
                     || s1_act.outer_tag_priority_select == PCP_SEL_FIXED) begin
            next_result.outer_pcp = s1_act.outer_tag_fixed_priority;
        end else begin
            next_result.outer_pcp = s1_frame.pcp;
        end
        // outer tag source
        case (s1_act.push_outer)
            2'h1:    next_result.outer_src = SRC_TAG_A;
            2'h2:    next_result.outer_src = SRC_PORT;
            2'h3:    next_result.outer_src = SRC_NONE;
            default: next_result.outer_src = port_tag ? SRC_PORT : SRC_NONE;
        endcase
        next_result.inner_src  = s1_act.push_inner ? SRC_TAG_B : SRC_NONE;
        next_result.push_count = 2'(next_result.outer_src != SRC_NONE)
                               + 2'(s1_act.push_inner);
        // port tag construction
        case (s1_port.port_tag_protocol_select)
            3'h0:    next_result.port_tpid = TPID_CTAG;
            3'h1:    next_result.port_tpid = TPID_STAG;
            3'h2:    next_result.port_tpid = custom_tag_protocol_id_i[0];
            3'h3:    next_result.port_tpid = custom_tag_protocol_id_i[1];
            default: next_result.port_tpid = custom_tag_protocol_id_i[2];
        endcase
        next_result.port_vid = s1_port.port_tag_vlan_select ? s1_port.port_default_vid
                                                            : s1_frame.vid;
        case (s1_port.port_tag_priority_select)
            2'h0:    next_result.port_pcp = s1_frame.pcp;
            2'h1:    next_result.port_pcp = s1_port.port_default_pcp;
            2'h2:    next_result.port_pcp = s1_port.port_priority_remap[color][s1_frame.qos_class];
            default: next_result.port_pcp = next_result.outer_pcp;
        endcase
        case (s1_port.port_tag_eligible_select)
            2'h0:    next_result.port_dei = s1_frame.dei;
            2'h1:    next_result.port_dei = s1_port.port_default_dei;
            2'h2:    next_result.port_dei = s1_port.port_eligible_remap[color][s1_frame.qos_class];
            default: next_result.port_dei = color;
        endcase
    end

    // output valid
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            out_valid_o <= 1'b0;
        end else if (!stall) begin
            out_valid_o <= s1_valid;
        end
    end

    // output data
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            result_o <= '0;
        end else if (!stall) begin
            result_o <= next_result;
        end
    end

    sequence s_advance;
        s1_valid && !stall;
    endsequence

    sequence s_lo_hit;
        s_advance ##0 s1_key_ok[1];
    endsequence

    a_out_hold: assert property (@(posedge core_clk_i) disable iff (reset_i)
        out_valid_o && !out_ready_i |=> out_valid_o && $stable(result_o))
        else $error("result changed while stalled");

    a_pop_bound: assert property (@(posedge core_clk_i) disable iff (reset_i)
        out_valid_o |-> result_o.pop_count <= result_o.present_tags)
        else $error("pop exceeds tags present");

    a_pop_extra: assert property (@(posedge core_clk_i) disable iff (reset_i)
        s1_valid |-> s1_pop <= {1'b0, s1_frame.header_tag_pop_count} + {2'h0, s1_act.tcam_extra_pop})
        else $error("pop above header plus one");

    a_tcam_gate: assert property (@(posedge core_clk_i) disable iff (reset_i)
        s1_valid && !s1_tcam_en |-> !s1_act.hit && s1_act.push_outer == 2'h0 && s1_pop <= MAX_HDR_POP)
        else $error("tcam action used while disabled");

    a_dscp_key: assert property (@(posedge core_clk_i) disable iff (reset_i)
        in_valid_i && action_i.key_select[1] == KEY_DSCP && !frame_i.is_ip |-> !key_ok[1])
        else $error("dscp key valid on non ip frame");

    a_table_one: assert property (@(posedge core_clk_i) disable iff (reset_i)
        s_lo_hit |=> result_o.map_lo_valid && result_o.map_lo == $past(res_a[1]))
        else $error("table one not preferred");

    a_pcp_mapped: assert property (@(posedge core_clk_i) disable iff (reset_i)
        s_lo_hit ##0 s1_act.outer_tag_priority_select == PCP_SEL_MAPPED
        |=> result_o.outer_pcp == $past(res_a[1].mapped_priority_code))
        else $error("outer priority not from table one");

    a_obey_tagged: assert property (@(posedge core_clk_i) disable iff (reset_i)
        s_advance ##0 (s1_port.require_original_tag && !s1_frame.originally_tagged_flag && !forced_port)
        |=> result_o.outer_src != SRC_PORT)
        else $error("port tag on untagged frame");

    a_mode_none: assert property (@(posedge core_clk_i) disable iff (reset_i)
        s_advance ##0 (s1_port.tag_mode == MODE_NONE && s1_act.push_outer == 2'h0)
        |=> result_o.outer_src == SRC_NONE)
        else $error("port tag pushed in none mode");

    a_base_unit: assert property (@(posedge core_clk_i) disable iff (reset_i)
        in_valid_i && action_i.key_select[1] == KEY_DSCP && key_ok[1]
        |-> rd_addr[1] == {act.table_base_index[1], 3'h0} + {5'h00, frame_i.dscp})
        else $error("dscp address not base times eight");

    a_push_count: assert property (@(posedge core_clk_i) disable iff (reset_i)
        s_advance |=> result_o.push_count == 2'(result_o.outer_src != SRC_NONE)
                                           + 2'(result_o.inner_src != SRC_NONE))
        else $error("push count disagrees with sources");

    a_port_tpid: assert property (@(posedge core_clk_i) disable iff (reset_i)
        s_advance ##0 (s1_port.port_tag_protocol_select == 3'h0)
        |=> result_o.port_tpid == TPID_CTAG)
        else $error("port tag protocol not default");
endmodule
`default_nettype wire

// *** egress_map_and_vlan_pop_tb.sv ***
// egress_map_and_vlan_pop_tb: directed checks of lookups and tag pop
// assumes the feeder model upstream and a sink that is ready except in the stall test
`timescale 1ns/10ps
`default_nettype none
module egress_map_and_vlan_pop_tb;
    import egress_map_pkg::*;
    logic              core_clk_i = 1'b0;
    logic              reset_i    = 1'b1;
    logic              go         = 1'b0;
    logic              tcam_en    = 1'b1;
    logic              out_rdy    = 1'b1;
    logic              wr_en      = 1'b0;
    logic              wr_res     = 1'b0;
    logic [ADDR_W-1:0] wr_addr    = '0;
    map_entry_t        wr_data    = '0;
    frame_info_t       fr         = '0;
    tcam_action_t      act        = '0;
    port_cfg_t         cfg        = '0;
    logic              in_valid;
    logic              in_ready;
    logic              out_valid;
    logic [2:0][15:0]  tpids;
    edit_result_t      res;
    map_entry_t        e0;
    map_entry_t        e1;
    int                n_errors        = 0;
    int                samples_checked = 0;
    always #5 core_clk_i = ~core_clk_i;
    frame_feeder i_frame_feeder (.core_clk_i(core_clk_i), .reset_i(reset_i), .go_i(go),
        .in_ready_i(in_ready), .in_valid_o(in_valid), .custom_tag_protocol_id_o(tpids));
    egress_map_and_vlan_pop i_egress_map_and_vlan_pop (.core_clk_i(core_clk_i), .reset_i(reset_i),
        .tcam_enable_i(tcam_en), .drop_level_to_color_i(4'h0), .custom_tag_protocol_id_i(tpids),
        .map_wr_en_i(wr_en), .map_wr_res_i(wr_res), .map_wr_addr_i(wr_addr), .map_wr_data_i(wr_data),
        .in_valid_i(in_valid), .in_ready_o(in_ready), .frame_i(fr), .action_i(act),
        .port_cfg_i(cfg), .out_valid_o(out_valid), .out_ready_i(out_rdy), .result_o(res));
    task automatic wrap_up();
        if (n_errors == 0 && samples_checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic r, input logic [ADDR_W-1:0] a, input map_entry_t d);
        @(posedge core_clk_i);
        wr_en <= 1'b1;
        wr_res <= r;
        wr_addr <= a;
        wr_data <= d;
        @(posedge core_clk_i);
        wr_en <= 1'b0;
    endtask
    task automatic send();
        int k;
        @(posedge core_clk_i);
        go <= 1'b1;
        @(posedge core_clk_i);
        go <= 1'b0;
        for (k = 0; k < 20 && out_valid !== 1'b1; k++) begin
            @(posedge core_clk_i);
            #1;
        end
        if (out_valid !== 1'b1) begin
            n_errors++;
            wrap_up();
        end
    endtask
    task automatic t_dscp_map();
        @(posedge core_clk_i);
        fr.is_ip <= 1'b1;
        send();
        chk(res.map_lo, e1);
        chk(res.outer_pcp, 3'h6);
    endtask
    task automatic t_fallback();
        @(posedge core_clk_i);
        fr.is_ip <= 1'b0;
        send();
        chk(res.map_lo, e0);
        chk(res.outer_pcp, 3'h4);
    endtask
    task automatic t_pop();
        @(posedge core_clk_i);
        fr.ethertypes <= {16'h0800, 16'h9100, 16'h88a8, 16'h8100};
        fr.header_tag_pop_count <= 2'h3;
        act.tcam_extra_pop <= 1'b1;
        send();
        chk(res.present_tags, 3'h3);
        chk(res.pop_count, 3'h3);
        @(posedge core_clk_i);
        fr.header_tag_pop_count <= 2'h1;
        send();
        chk(res.pop_count, 3'h2);
    endtask
    task automatic t_stall();
        @(posedge core_clk_i);
        out_rdy <= 1'b0;
        send();
        repeat (3) @(posedge core_clk_i);
        #1;
        chk(in_ready, 1'b0);
        chk(out_valid, 1'b1);
        chk(res.pop_count, 3'h2);
        @(posedge core_clk_i);
        out_rdy <= 1'b1;
    endtask
    task automatic t_tcam_off();
        @(posedge core_clk_i);
        tcam_en <= 1'b0;
        send();
        chk(res.map_lo_valid, 1'b0);
        chk(res.pop_count, 3'h1);
        @(posedge core_clk_i);
        tcam_en <= 1'b1;
    endtask
    task automatic t_port_tag();
        @(posedge core_clk_i);
        cfg.require_original_tag <= 1'b1;
        send();
        chk(res.outer_src, SRC_NONE);
        @(posedge core_clk_i);
        fr.originally_tagged_flag <= 1'b1;
        send();
        chk(res.outer_src, SRC_PORT);
        chk(res.push_count, 2'h1);
        chk(res.port_tpid, TPID_CTAG);
        @(posedge core_clk_i);
        cfg.tag_mode <= 2'h3;
        send();
        chk(res.outer_src, SRC_NONE);
    endtask
    task automatic t_no_hit();
        @(posedge core_clk_i);
        act.hit <= 1'b0;
        send();
        chk(res.map_lo_valid, 1'b0);
        chk(res.outer_pcp, 3'h3);
    endtask
    initial begin
        e0 = '{3'h1, 6'h2a, 1'b1, 3'h4, 1'b0, 3'h5, 20'habcde};
        e1 = '{3'h7, 6'h15, 1'b0, 3'h6, 1'b1, 3'h2, 20'h12345};
        act.hit = 1'b1;
        act.key_select[1] = 4'h2;
        act.table_base_index[1] = 8'h20;
        act.outer_tag_priority_select = 3'h5;
        act.outer_tag_fixed_priority = 3'h3;
        fr.dscp = 6'h05;
        fr.pcp = 3'h2;
        repeat (6) @(posedge core_clk_i);
        reset_i <= 1'b0;
        wr(1'b0, 11'h105, e1);
        wr(1'b0, 11'h002, e0);
        t_dscp_map();
        t_fallback();
        t_pop();
        t_stall();
        t_tcam_off();
        t_no_hit();
        t_port_tag();
        wrap_up();
    end
endmodule
`default_nettype wire

// *** egress_map_pkg.sv ***
// egress_map_pkg: constants and carrier types of the egress rewriter
// assumes one clock domain and frame descriptors given per frame
package egress_map_pkg;
    localparam int MAP_DEPTH       = 2048;
    localparam int ADDR_W          = 11;
    localparam int BASE_W          = 8;
    localparam int BASE_SHIFT      = 3;
    localparam int NUM_TABLES      = 4;
    localparam int NUM_CUSTOM_TPID = 3;
    localparam int TAG_SCAN        = 4;
    localparam logic [1:0]  MAX_HDR_POP    = 2'h3;
    localparam logic [2:0]  PCP_SEL_MAPPED = 3'h5;
    localparam logic [2:0]  PCP_SEL_FIXED  = 3'h1;
    localparam logic [15:0] TPID_CTAG      = 16'h8100;
    localparam logic [15:0] TPID_STAG      = 16'h88a8;

    typedef enum logic [3:0] {
        KEY_PCP       = 4'h0,
        KEY_DEI_PCP   = 4'h1,
        KEY_DSCP      = 4'h2,
        KEY_TC        = 4'h3,
        KEY_QOS       = 4'h4,
        KEY_DP_QOS    = 4'h5,
        KEY_COLOR_QOS = 4'h6,
        KEY_COSID     = 4'h7,
        KEY_VID       = 4'h8,
        KEY_NONE      = 4'hf
    } key_sel_t;

    typedef enum logic [1:0] {
        MODE_ALL      = 2'h0,
        MODE_EXC_PVID = 2'h1,
        MODE_EXC_ZERO = 2'h2,
        MODE_NONE     = 2'h3
    } tag_mode_t;

    typedef enum logic [2:0] {
        SRC_NONE  = 3'h0,
        SRC_PORT  = 3'h1,
        SRC_TAG_A = 3'h2,
        SRC_TAG_B = 3'h3,
        SRC_TAG_C = 3'h4,
        SRC_ROUTE = 3'h5
    } tag_src_t;

    typedef struct packed {
        logic [2:0]  mapped_traffic_class;
        logic [5:0]  mapped_diffserv_code;
        logic        mapped_drop_eligible;
        logic [2:0]  mapped_priority_code;
        logic        mapped_a;
        logic [2:0]  mapped_oam_class;
        logic [19:0] mapped_label;
    } map_entry_t;

    typedef struct packed {
        logic [1:0]          header_tag_pop_count;
        logic                originally_tagged_flag;
        logic                is_ip;
        logic                is_mpls;
        logic [5:0]          dscp;
        logic [2:0]          tc;
        logic [2:0]          pcp;
        logic                dei;
        logic [1:0]          dp;
        logic [2:0]          qos_class;
        logic [2:0]          cosid;
        logic [11:0]         vid;
        logic [3:0][15:0]    ethertypes;
    } frame_info_t;

    typedef struct packed {
        logic                  hit;
        logic [1:0]            push_outer;
        logic                  push_inner;
        logic                  tcam_extra_pop;
        logic [2:0]            outer_tag_priority_select;
        logic [2:0]            outer_tag_fixed_priority;
        logic [3:0][BASE_W-1:0] table_base_index;
        logic [3:0][3:0]       key_select;
    } tcam_action_t;

    typedef struct packed {
        logic [11:0]     port_default_vid;
        logic [2:0]      port_default_pcp;
        logic            port_default_dei;
        logic            require_original_tag;
        logic [1:0]      tag_mode;
        logic [2:0]      port_tag_protocol_select;
        logic            port_tag_vlan_select;
        logic [1:0]      port_tag_priority_select;
        logic [1:0]      port_tag_eligible_select;
        logic [1:0][7:0][2:0] port_priority_remap;
        logic [1:0][7:0] port_eligible_remap;
    } port_cfg_t;

    typedef struct packed {
        map_entry_t  map_lo;
        logic        map_lo_valid;
        map_entry_t  map_hi;
        logic        map_hi_valid;
        logic [2:0]  outer_pcp;
        logic [2:0]  pop_count;
        logic [2:0]  present_tags;
        logic [1:0]  push_count;
        tag_src_t    outer_src;
        tag_src_t    inner_src;
        logic [15:0] port_tpid;
        logic [11:0] port_vid;
        logic [2:0]  port_pcp;
        logic        port_dei;
    } edit_result_t;
endpackage

// *** frame_feeder.sv ***
// frame_feeder: upstream model presenting one descriptor per request
// assumes the bench holds descriptor fields while valid is up
`timescale 1ns/10ps
`default_nettype none
module frame_feeder (
    // clock and reset
    input  wire logic        core_clk_i,
    input  wire logic        reset_i,
    // request and handshake
    input  wire logic        go_i,
    input  wire logic        in_ready_i,
    output logic             in_valid_o,
    output logic [2:0][15:0] custom_tag_protocol_id_o
);
    // same values as the classifier service ethertypes
    assign custom_tag_protocol_id_o = {16'h9300, 16'h9200, 16'h9100};
    always_ff @(posedge core_clk_i) begin
        if (reset_i) in_valid_o <= 1'b0;
        else if (go_i) in_valid_o <= 1'b1;
        else if (in_ready_i) in_valid_o <= 1'b0;
    end
endmodule
`default_nettype wire

// *** mapping_resource.sv ***
// mapping_resource: one 2048-entry field mapping store, two read ports
// assumes software writes are rare; reads are taken on rd_en_i
`timescale 1ns/10ps
`default_nettype none
module mapping_resource
    import egress_map_pkg::*;
#(
    parameter int DEPTH = MAP_DEPTH
) (
    // clock
    input  wire logic                          core_clk_i,
    // software write
    input  wire logic                          wr_en_i,
    input  wire logic [ADDR_W-1:0]             wr_addr_i,
    input  wire egress_map_pkg::map_entry_t    wr_data_i,
    // lookups
    input  wire logic                          rd_en_i,
    input  wire logic [1:0][ADDR_W-1:0]        rd_addr_i,
    output egress_map_pkg::map_entry_t [1:0]   rd_data_o
);
    map_entry_t mem [DEPTH];

    // table storage
    always_ff @(posedge core_clk_i) begin
        if (wr_en_i) begin
            mem[wr_addr_i] <= wr_data_i;
        end
    end

    // two lookups per frame
    for (genvar i = 0; i < 2; i++) begin : g_rd
        always_ff @(posedge core_clk_i) begin
            if (rd_en_i) begin
                rd_data_o[i] <= mem[rd_addr_i[i]];
            end
        end
    end
endmodule
`default_nettype wire

// *** vlan_tag_scan.sv ***
// vlan_tag_scan: counts leading vlan tags and bounds the pop count
// assumes ethertypes are given outermost first
`timescale 1ns/10ps
`default_nettype none
module vlan_tag_scan
    import egress_map_pkg::*;
(
    // frame view
    input  wire logic [3:0][15:0]                 ethertypes_i,
    input  wire logic [NUM_CUSTOM_TPID-1:0][15:0] custom_tag_protocol_id_i,
    // pop request
    input  wire logic [1:0]                       header_pop_i,
    input  wire logic                             extra_pop_i,
    // result
    output logic [2:0]                            present_o,
    output logic [2:0]                            pop_o
);
    logic [TAG_SCAN-1:0] is_tag;
    logic [2:0]          want;

    for (genvar i = 0; i < TAG_SCAN; i++) begin : g_tag
        assign is_tag[i] = ethertypes_i[i] == TPID_CTAG
                        || ethertypes_i[i] == TPID_STAG
                        || ethertypes_i[i] == custom_tag_protocol_id_i[0]
                        || ethertypes_i[i] == custom_tag_protocol_id_i[1]
                        || ethertypes_i[i] == custom_tag_protocol_id_i[2];
    end

    // leading run of tags
    always_comb begin
        present_o = 3'h0;
        for (int i = TAG_SCAN - 1; i >= 0; i--) begin
            if (!is_tag[i]) begin
                present_o = 3'(i);
            end
        end
        if (&is_tag) begin
            present_o = 3'(TAG_SCAN);
        end
    end

    // header count raised by tcam, bounded by tags present
    always_comb begin
        want  = {1'b0, header_pop_i} + {2'h0, extra_pop_i};
        pop_o = (want > present_o) ? present_o : want;
    end
endmodule
`default_nettype wire
